// [rtl/usb_ep_irq_pkg.sv]
// constants and carriers shared by the endpoint interrupt force and routing block
`default_nettype none

package usb_ep_irq_pkg;

    // ----------------------------------------
    // bus geometry
    // ----------------------------------------
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int STRB_W = DATA_W / 8;

    // ----------------------------------------
    // register byte addresses
    // ----------------------------------------
    localparam logic [ADDR_W-1:0] FORCE_OFFSET = 32'h8004_10a4;
    localparam logic [ADDR_W-1:0] ROUTE_OFFSET = 32'h8004_10a8;
    localparam logic [ADDR_W-1:0] PENDING_OFFSET = 32'h8004_10b0;
    localparam logic [ADDR_W-1:0] EVT_STATUS_OFFSET = 32'h8004_10b4;
    localparam logic [ADDR_W-1:0] EVT_MASK_OFFSET = 32'h8004_10b8;

    // ----------------------------------------
    // reset values and responses
    // ----------------------------------------
    localparam logic [15:0] ROUTE_RESET = 16'h0000;
    localparam logic [15:0] PENDING_RESET = 16'h0000;
    localparam logic [15:0] EVT_STATUS_RESET = 16'h0000;
    localparam logic [15:0] EVT_MASK_RESET = 16'h0000;
    localparam logic [DATA_W-1:0] FORCE_READ_VALUE = 32'h0000_0000;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_DECERR = 2'b11;

    // ----------------------------------------
    // carriers
    // ----------------------------------------
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic [STRB_W-1:0] strb;
    } wr_req_s;

endpackage

`default_nettype wire

// [rtl/usb_ep_irq_force_route.sv]
// endpoint interrupt pending, force, routing onto two request lines, axi4-lite slave
//
// What this block does
// - force write of one sets endpoint interrupt
// - exactly two request outputs, numbered zero, one
// - route bit selects request zero or one
// - disabled pending interrupts never drive requests
// - routing clears on master and bus reset
// - zero writes ignored, force reads zero
// - buffer filled or emptied sets interrupt
`default_nettype none

module usb_ep_irq_force_route
    import usb_ep_irq_pkg::*;
#(
    parameter int NUM_EP = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic usb_bus_reset,
    input wire logic [NUM_EP-1:0] ep_rx_filled,
    input wire logic [NUM_EP-1:0] ep_tx_emptied,
    input wire logic [2*NUM_EP-1:0] ep_irq_enable,
    input wire logic [2*NUM_EP-1:0] ep_irq_clear,
    output logic irq_req0,
    output logic irq_req1,
    output logic irq,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [DATA_W-1:0] s_axi_wdata,
    input wire logic [STRB_W-1:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    localparam int SRC_W = 2 * NUM_EP;

    // refused at elaboration: the register map only has room for eight endpoints
    if (NUM_EP < 1 || NUM_EP > 8) begin : g_bad_num_ep
        $error("NUM_EP must lie in 1..8");
    end

    // ----------------------------------------
    // state
    // ----------------------------------------
    wr_req_s wr_q;
    logic aw_held_q, w_held_q, awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic [1:0] bresp_q, rresp_q;
    logic [DATA_W-1:0] rdata_q;
    logic [SRC_W-1:0] pending_q, pending_d, route_q, route_d, evt_q, evt_d, mask_q, mask_d;
    logic req0_q, req1_q, irq_q;

    // ----------------------------------------
    // write channel
    // ----------------------------------------
    wire aw_fire = s_axi_awvalid && awready_q;
    wire w_fire = s_axi_wvalid && wready_q;
    // one write at a time; the response must drain before the next commits
    wire wr_go = aw_held_q && w_held_q && !bvalid_q;
    wire aw_held_d = aw_fire || (aw_held_q && !wr_go);
    wire w_held_d = w_fire || (w_held_q && !wr_go);
    wire force_hit = wr_q.addr == FORCE_OFFSET;
    wire route_hit = wr_q.addr == ROUTE_OFFSET;
    wire mask_hit = wr_q.addr == EVT_MASK_OFFSET;
    wire wr_mapped = force_hit || route_hit || mask_hit || (wr_q.addr == PENDING_OFFSET)
        || (wr_q.addr == EVT_STATUS_OFFSET);
    wire [15:0] strb_bits = {{8{wr_q.strb[1]}}, {8{wr_q.strb[0]}}};
    wire [SRC_W-1:0] wr_bits = wr_q.data[SRC_W-1:0] & strb_bits[SRC_W-1:0];
    wire [SRC_W-1:0] force_set = (wr_go && force_hit) ? wr_bits : '0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            wr_q <= '0;
        end else begin
            aw_held_q <= aw_held_d;
            w_held_q <= w_held_d;
            awready_q <= !aw_held_d;
            wready_q <= !w_held_d;
            if (aw_fire) begin
                wr_q.addr <= s_axi_awaddr;
            end
            if (w_fire) begin
                wr_q.data <= s_axi_wdata;
                wr_q.strb <= s_axi_wstrb;
            end
            if (wr_go) begin
                bvalid_q <= 1'b1;
                bresp_q <= wr_mapped ? RESP_OKAY : RESP_DECERR;
            end else if (s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // read channel
    // ----------------------------------------
    wire ar_fire = s_axi_arvalid && arready_q;
    wire rvalid_d = ar_fire || (rvalid_q && !s_axi_rready);
    wire rd_force = s_axi_araddr == FORCE_OFFSET;
    wire rd_route = s_axi_araddr == ROUTE_OFFSET;
    wire rd_pend = s_axi_araddr == PENDING_OFFSET;
    wire rd_evt = s_axi_araddr == EVT_STATUS_OFFSET;
    wire rd_mask = s_axi_araddr == EVT_MASK_OFFSET;
    wire rd_mapped = rd_force || rd_route || rd_pend || rd_evt || rd_mask;
    // force always reads zero; upper route bits read zero rather than undefined
    wire [SRC_W-1:0] rd_bits = rd_route ? route_q : rd_pend ? pending_q : rd_evt ? evt_q
        : rd_mask ? mask_q : '0;
    wire [DATA_W-1:0] rd_word = rd_force ? FORCE_READ_VALUE : {{(DATA_W-SRC_W){1'b0}}, rd_bits};
    wire [SRC_W-1:0] evt_rd_clr = (ar_fire && rd_evt) ? evt_q : '0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= RESP_OKAY;
        end else begin
            arready_q <= !rvalid_d;
            rvalid_q <= rvalid_d;
            if (ar_fire) begin
                rdata_q <= rd_mapped ? rd_word : '0;
                rresp_q <= rd_mapped ? RESP_OKAY : RESP_DECERR;
            end
        end
    end

    // ----------------------------------------
    // endpoint sources, pending, routing
    // ----------------------------------------
    wire [SRC_W-1:0] hw_event;
    genvar n;
    generate
        for (n = 0; n < NUM_EP; n++) begin : g_ep
            assign hw_event[2*n] = ep_rx_filled[n];
            assign hw_event[2*n+1] = ep_tx_emptied[n];
        end
    endgenerate

    // hardware and forced sets behave alike; a set beats a same-cycle clear
    wire [SRC_W-1:0] set_vec = hw_event | force_set;
    wire [SRC_W-1:0] active = pending_q & ep_irq_enable;
    wire req0_d = |(active & ~route_q);
    wire req1_d = |(active & route_q);

    assign pending_d = usb_bus_reset ? PENDING_RESET[SRC_W-1:0] : ((pending_q & ~ep_irq_clear) | set_vec);
    assign route_d = usb_bus_reset ? ROUTE_RESET[SRC_W-1:0]
        : (wr_go && route_hit) ? wr_bits | (route_q & ~strb_bits[SRC_W-1:0]) : route_q;
    assign evt_d = usb_bus_reset ? EVT_STATUS_RESET[SRC_W-1:0] : ((evt_q & ~evt_rd_clr) | (set_vec & ~pending_q));
    assign mask_d = (wr_go && mask_hit) ? wr_bits | (mask_q & ~strb_bits[SRC_W-1:0]) : mask_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pending_q <= PENDING_RESET[SRC_W-1:0];
            route_q <= ROUTE_RESET[SRC_W-1:0];
            evt_q <= EVT_STATUS_RESET[SRC_W-1:0];
            mask_q <= EVT_MASK_RESET[SRC_W-1:0];
            req0_q <= 1'b0;
            req1_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            pending_q <= pending_d;
            route_q <= route_d;
            evt_q <= evt_d;
            mask_q <= mask_d;
            req0_q <= req0_d;
            req1_q <= req1_d;
            irq_q <= |(evt_q & mask_q);
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign irq_req0 = req0_q;
    assign irq_req1 = req1_q;
    assign irq = irq_q;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    force_sets_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (force_set != '0 && !usb_bus_reset) |=> ((pending_q & $past(force_set)) == $past(force_set)))
        else $error("forced endpoint interrupt not set");

    zero_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_go && force_hit && hw_event == '0 && ep_irq_clear == '0 && !usb_bus_reset)
        |=> pending_q == ($past(pending_q) | $past(wr_bits)))
        else $error("force write disturbed unselected bits");

    force_reads_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (ar_fire && rd_force) |=> (s_axi_rvalid && s_axi_rdata == FORCE_READ_VALUE))
        else $error("force register read nonzero");

    route_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (|(active & ~route_q)) |=> irq_req0)
        else $error("request zero missing for routed interrupt");

    route_one_a: assert property (@(posedge aclk) disable iff (!aresetn)
        irq_req1 |-> $past(|(pending_q & ep_irq_enable & route_q)))
        else $error("request one without routed source");

    disabled_quiet_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (active == '0) |=> (!irq_req0 && !irq_req1))
        else $error("disabled interrupt drove a request");

    bus_reset_route_a: assert property (@(posedge aclk) disable iff (!aresetn)
        usb_bus_reset |=> (route_q == '0 ##1 !irq_req1))
        else $error("routing not cleared by bus reset");

    hw_event_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (hw_event != '0 && !usb_bus_reset) |=> ((pending_q & $past(hw_event)) == $past(hw_event)))
        else $error("buffer event did not set pending");

    req_release_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (active != '0 && ep_irq_clear == '0 && set_vec == '0 && !usb_bus_reset
        && ep_irq_enable == $past(ep_irq_enable))
        |=> (irq_req0 || irq_req1) ##1 ((irq_req0 || irq_req1) == $past(active != '0)))
        else $error("request did not follow pending interrupts");

endmodule // usb_ep_irq_force_route

`default_nettype wire

// [tb/vic_model.sv]
// model of the system interrupt controller watching the two request lines
`default_nettype none
module vic_model (
    input wire logic irq_req0,
    input wire logic irq_req1,
    output logic [1:0] grant
);
    timeunit 1ns;
    timeprecision 1ps;
    // line 1 wins a tie, so urgent endpoints can go to the fast input
    assign grant = irq_req1 ? 2'h2 : (irq_req0 ? 2'h1 : 2'h0);
endmodule // vic_model
`default_nettype wire

// [tb/usb_endpoint_irq_force_route_tb.sv]
// self-checking bench for the endpoint interrupt force and routing block
`default_nettype none
module usb_endpoint_irq_force_route_tb
    import usb_ep_irq_pkg::*;
    ;
    timeunit 1ns;
    timeprecision 1ps;
    // ----
    // signals and instances
    // ----
    logic aclk = '0, aresetn = '0, usb_bus_reset = '0, irq_req0, irq_req1, irq;
    logic [7:0] ep_rx_filled = '0, ep_tx_emptied = '0;
    logic [15:0] ep_irq_enable = '0, ep_irq_clear = '0, r;
    logic [1:0] grant, s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = '0;
    logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0, s_axi_arvalid = '0, s_axi_rready = '0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    int bad_count = 0, comparisons = 0, n;
    logic [33:0] exp_q[$];
    logic [1:0] bexp_q[$];
    always #2.5 aclk = ~aclk;
    usb_ep_irq_force_route dut (.aclk, .aresetn, .usb_bus_reset, .ep_rx_filled, .ep_tx_emptied,
        .ep_irq_enable, .ep_irq_clear, .irq_req0, .irq_req1, .irq, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    vic_model far (.irq_req0, .irq_req1, .grant);
    // ----
    // tasks
    // ----
    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_req(input logic e1, input logic e0, input logic ei);
        chk({irq, irq_req1, irq_req0, grant}, {ei, e1, e0, e1 ? 2'h2 : (e0 ? 2'h1 : 2'h0)});
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge aclk);
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] e = RESP_OKAY,
        input logic [3:0] s = 4'hf);
        bit aw, w;
        aw = 0;
        w = 0;
        bexp_q.push_back(e);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= '1;
        s_axi_wvalid <= '1;
        s_axi_bready <= '1;
        do begin
            @(posedge aclk);
            if (!aw && s_axi_awready) begin
                aw = 1;
                s_axi_awvalid <= '0;
            end
            if (!w && s_axi_wready) begin
                w = 1;
                s_axi_wvalid <= '0;
            end
        end while (!s_axi_bvalid);
        s_axi_bready <= '0;
    endtask
    // expectation noted first, the monitor below settles it
    task automatic rd(input logic [31:0] a, input logic [33:0] e);
        exp_q.push_back(e);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= '1;
        s_axi_rready <= '1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= '0;
        end while (!s_axi_rvalid);
        s_axi_rready <= '0;
    endtask
    always @(posedge aclk) if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
    always @(posedge aclk) if (s_axi_bvalid && s_axi_bready) chk({32'h0, s_axi_bresp}, {32'h0, bexp_q.pop_front()});
    task automatic summarize;
        $display("bad_count %0d comparisons %0d", bad_count, comparisons);
        if (bad_count == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // ----
    // scenarios
    // ----
    initial begin
        #50000;
        bad_count++;
        summarize();
    end
    initial begin
        void'($urandom(85));
        tick(3);
        aresetn <= '1;
        rd(ROUTE_OFFSET, {RESP_OKAY, 32'h0});
        rd(FORCE_OFFSET, {RESP_OKAY, FORCE_READ_VALUE});
        rd(32'h8004_10ac, {RESP_DECERR, 32'h0});
        wr(32'h8004_10ac, 32'hffff, RESP_DECERR);
        // only the second byte lane is enabled, the low routing byte keeps its reset value
        wr(ROUTE_OFFSET, 32'hffff, RESP_OKAY, 4'h2);
        rd(ROUTE_OFFSET, {RESP_OKAY, 32'hff00});
        ep_irq_enable <= 16'hffff;
        r = 16'($urandom);
        wr(ROUTE_OFFSET, {16'h0, r});
        rd(ROUTE_OFFSET, {RESP_OKAY, 16'h0, r});
        for (int i = 0; i < 16; i++) begin
            wr(FORCE_OFFSET, 32'h1 << i);
            wr(FORCE_OFFSET, 32'h0);
            tick(2);
            cmp_req(r[i], !r[i], '0);
            rd(PENDING_OFFSET, {RESP_OKAY, 32'h1 << i});
            ep_irq_clear <= 16'h1 << i;
            tick(1);
            ep_irq_clear <= '0;
            tick(3);
            cmp_req('0, '0, '0);
        end
        // pending but disabled must stay off both lines
        ep_irq_enable <= '0;
        wr(FORCE_OFFSET, 32'hffff);
        tick(3);
        cmp_req('0, '0, '0);
        ep_irq_enable <= 16'hffff;
        tick(3);
        cmp_req(|r, |(~r), '0);
        rd(EVT_STATUS_OFFSET, {RESP_OKAY, 32'hffff});
        ep_irq_clear <= 16'hffff;
        tick(1);
        ep_irq_clear <= '0;
        wr(EVT_MASK_OFFSET, 32'hffff);
        n = $urandom_range(7, 0);
        ep_rx_filled <= 8'h1 << n;
        ep_tx_emptied <= 8'h1 << n;
        tick(1);
        ep_rx_filled <= '0;
        ep_tx_emptied <= '0;
        tick(3);
        cmp_req(r[2*n] | r[2*n+1], !r[2*n] | !r[2*n+1], '1);
        rd(PENDING_OFFSET, {RESP_OKAY, 32'h3 << (2 * n)});
        rd(EVT_STATUS_OFFSET, {RESP_OKAY, 32'h3 << (2 * n)});
        tick(3);
        cmp_req(r[2*n] | r[2*n+1], !r[2*n] | !r[2*n+1], '0);
        // bus reset with work pending, then a second master reset
        wr(ROUTE_OFFSET, 32'hffff);
        usb_bus_reset <= '1;
        tick(1);
        usb_bus_reset <= '0;
        tick(3);
        cmp_req('0, '0, '0);
        rd(ROUTE_OFFSET, {RESP_OKAY, 32'h0});
        wr(ROUTE_OFFSET, 32'hffff);
        aresetn <= '0;
        tick(2);
        aresetn <= '1;
        rd(ROUTE_OFFSET, {RESP_OKAY, 32'h0});
        tick(2);
        summarize();
    end
endmodule // usb_endpoint_irq_force_route_tb
`default_nettype wire
